// >>> include/cssq_pkg.sv
package cssq_pkg;
    // Register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] REG_CLK_SEL = 4'h0;
    localparam logic [3:0] REG_PRESCALE = 4'h1;
    localparam logic [3:0] REG_PLL = 4'h2;
    localparam logic [3:0] REG_SLEEP = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_FUSES = 4'h5;
    // Field positions
    localparam int CLK_SRC_LSB = 0;
    localparam int CLK_EXT_EN_BIT = 2;
    localparam int PLL_EN_BIT = 0;
    localparam int PLL_LOCK_BIT = 1;
    localparam int SLEEP_GO_BIT = 7;
    localparam int STAT_RESUME_BIT = 3;
    localparam int STAT_RST_BIT = 4;
    localparam int FUSE_SUT_LSB = 4;
    localparam int FUSE_DIV8_BIT = 6;
    // Clock source select fuse codes, one means unprogrammed
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_EXT = 4'h0;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_RC = 4'h2;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_FS_LO = 4'h6;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_FS_HI = 4'h7;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_LP_LO = 4'h8;
    localparam logic FUSE_PROGRAMMED = 1'b0;
    localparam logic [1:0] SUT_NONE = 2'h0;
    localparam logic [1:0] SUT_SHORT = 2'h1;
    localparam logic [1:0] SUT_LONG = 2'h2;
    // Source kinds on the multiplexer
    typedef enum logic [1:0] {SRC_EXT, SRC_RC, SRC_LP_XTAL, SRC_FS_XTAL} cssq_src_t;
    typedef enum logic [1:0] {SLP_IDLE, SLP_PSAVE, SLP_PDOWN} cssq_slp_t;
    typedef enum logic [2:0] {ST_RESET, ST_TOUT, ST_OSC, ST_RUN, ST_SLEEP} cssq_state_t;
    // Watchdog oscillator cycles of the reset time-out
    localparam int CNT_W = 16;
    localparam logic [15:0] TOUT_NONE = 16'h0000;
    localparam logic [15:0] TOUT_SHORT = 16'h0200;
    localparam logic [15:0] TOUT_LONG = 16'h2000;
    // Oscillator start-up counts
    localparam logic [15:0] OSC_CNT_EXT = 16'h0006;
    localparam logic [15:0] OSC_CNT_RC = 16'h0006;
    localparam logic [15:0] OSC_CNT_258 = 16'h0102;
    localparam logic [15:0] OSC_CNT_1K = 16'h0400;
    localparam logic [15:0] OSC_CNT_16K = 16'h4000;
    localparam logic [15:0] OSC_CNT_MAX = 16'h8000;
    localparam logic [15:0] OSC_RST_EXTRA = 16'h000E;
    // Prescaler: divide by two to the power n
    localparam logic [3:0] PRESC_DIV1 = 4'h0;
    localparam logic [3:0] PRESC_DIV8 = 4'h3;
    localparam logic [3:0] PRESC_MAX = 4'h8;
    localparam int PRESC_CNT_W = 8;
    // USB PLL
    localparam int PLL_MULT = 6;
    localparam int USB_CLK_MHZ = 48;
    localparam int PLL_IN_MHZ = USB_CLK_MHZ / PLL_MULT;
    localparam int CORE_CLK_MHZ = 20;
endpackage : cssq_pkg

// >>> hdl/cssq_tick_counter.sv
`timescale 1ns/1ps
module cssq_tick_counter
    import cssq_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_clear,
    input wire logic i_tick,
    input wire logic [CNT_W-1:0] i_target,
    output logic o_done
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic done;
    } cssq_cnt_state_t;

    cssq_cnt_state_t s_r;
    cssq_cnt_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (i_clear) begin
            // Restart from zero at every time-out start or oscillator start
            s_nxt.cnt = '0;
            s_nxt.done = 1'b0;
        end else begin
            if (i_tick && !s_r.done) begin
                s_nxt.cnt = s_r.cnt + 1'b1;
            end
            s_nxt.done = (s_nxt.cnt >= i_target);
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_done = s_r.done;
endmodule : cssq_tick_counter

// >>> hdl/cssq_clock_sequencer.sv
`timescale 1ns/1ps
// Operation
// - Selected source drives the clock generator; generated enables reach each domain.
// - Sleep modes stop the clocks of unused domains.
// - Core clock stops in sleep; core work halts without it.
// - Peripheral clock drives timers; async interrupts still wake with it stopped.
// - Flash interface clock runs together with the core clock.
// - USB clock from PLL times six; software sets PLL input to 8 MHz.
// - Software may change multiplexer and prescaler at run time.
// - On event or USB resume firmware switches back to external clock.
// - Four-bit source fuse decodes crystal, full swing, RC, external, reserved.
// - Fuse value one means unprogrammed, zero means programmed.
// - Default fuses give RC, long time-out, divide by eight.
// - Internal reset stays for a time-out after other resets release.
// - Time-out counts 0, 512 or 8192 watchdog cycles chosen by fuses.
// - Brown-out detector holds reset until supply is adequate.
// - Ripple counter on oscillator output holds reset for the start-up count.
// - Start-up count depends on clock type, 6 up to 16K cycles.
// - Reset applies time-out and start-up count; wake from power-save or power-down applies start-up only, idle wake neither.
// - RC wake takes 6 clocks; reset adds 14 clocks to time-out.
// - Programmed divide-by-eight fuse divides the system clock by eight.
module cssq_clock_sequencer
    import cssq_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [3:0] i_clock_source_select_fuses,
    input wire logic [1:0] i_startup_time_fuses,
    input wire logic i_divide_by_eight_fuse,
    input wire logic i_reset_source,
    input wire logic i_brownout_detector,
    input wire logic i_wdt_osc_tick,
    input wire logic i_osc_tick,
    input wire logic i_wake,
    input wire logic i_async_irq,
    input wire logic i_usb_non_idle,
    input wire logic i_pll_locked,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [DATA_W-1:0] o_rd_data,
    output logic o_int_rst,
    output logic o_core_clock_en,
    output logic o_peripheral_clock_en,
    output logic o_flash_interface_clock_en,
    output logic o_usb_domain_clock_en,
    output logic o_pll_en,
    output logic [1:0] o_clk_src,
    output logic o_rc_osc_en,
    output logic o_ext_osc_en,
    output logic o_osc_run
);
    typedef struct packed {
        cssq_state_t state;
        logic [3:0] clock_source_select_fuses;
        logic [1:0] startup_time_fuses;
        logic div8;
        logic from_reset;
        cssq_src_t src;
        logic ext_en;
        logic [3:0] presc;
        logic [PRESC_CNT_W-1:0] presc_cnt;
        logic pll_en;
        cssq_slp_t slp_mode;
        logic resume_flag;
        logic tout_clr;
        logic osc_clr;
        logic int_rst;
        logic core_en;
        logic per_en;
        logic flash_en;
        logic usb_en;
        logic rc_en;
        logic ext_osc;
        logic osc_run;
        logic [DATA_W-1:0] rd_data;
    } cssq_state_s_t;

    cssq_state_s_t s_r;
    cssq_state_s_t s_nxt;
    logic tout_done;
    logic osc_done;
    logic [CNT_W-1:0] tout_target;
    logic [CNT_W-1:0] osc_target;

    // Decode the four-bit source fuse; reserved codes fall back to the RC oscillator
    function automatic cssq_src_t cssq_src_of(input logic [3:0] ck);
        if (ck >= CLOCK_SOURCE_SELECT_FUSES_LP_LO) begin
            return SRC_LP_XTAL;
        end else if (ck == CLOCK_SOURCE_SELECT_FUSES_FS_LO || ck == CLOCK_SOURCE_SELECT_FUSES_FS_HI) begin
            return SRC_FS_XTAL;
        end else if (ck == CLOCK_SOURCE_SELECT_FUSES_EXT) begin
            return SRC_EXT;
        end else begin
            return SRC_RC;
        end
    endfunction : cssq_src_of

    // Watchdog cycles of the reset time-out
    function automatic logic [CNT_W-1:0] cssq_tout_of(input logic [3:0] ck, input logic [1:0] startup_time_fuses);
        logic [2:0] sel;
        sel = {ck[0], startup_time_fuses};
        if (cssq_src_of(ck) == SRC_RC || cssq_src_of(ck) == SRC_EXT) begin
            if (startup_time_fuses == SUT_SHORT) begin
                return TOUT_SHORT;
            end else if (startup_time_fuses == SUT_LONG) begin
                return TOUT_LONG;
            end else begin
                return TOUT_NONE;
            end
        end else if (sel == 3'h2 || sel == 3'h5) begin
            return TOUT_NONE;
        end else if (sel == 3'h0 || sel == 3'h3 || sel == 3'h6) begin
            return TOUT_SHORT;
        end else begin
            return TOUT_LONG;
        end
    endfunction : cssq_tout_of

    // Oscillator start-up count for the fuse-selected source
    function automatic logic [CNT_W-1:0] cssq_osc_of(input logic [3:0] ck, input logic [1:0] startup_time_fuses);
        logic [2:0] sel;
        sel = {ck[0], startup_time_fuses};
        if (cssq_src_of(ck) == SRC_RC) begin
            return OSC_CNT_RC;
        end else if (cssq_src_of(ck) == SRC_EXT) begin
            return OSC_CNT_EXT;
        end else if (sel == 3'h0 || sel == 3'h1) begin
            return OSC_CNT_258;
        end else if (sel <= 3'h4) begin
            return OSC_CNT_1K;
        end else begin
            return OSC_CNT_16K;
        end
    endfunction : cssq_osc_of

    // Prescaler terminal count for divide by two to the power n
    function automatic logic [PRESC_CNT_W-1:0] cssq_presc_mask(input logic [3:0] n);
        logic [PRESC_CNT_W:0] one_hot;
        one_hot = '0;
        one_hot[n] = 1'b1;
        return PRESC_CNT_W'(one_hot - 1'b1);
    endfunction : cssq_presc_mask

    assign tout_target = cssq_tout_of(s_r.clock_source_select_fuses, s_r.startup_time_fuses);
    // The 14 extra clocks only apply on the way out of reset
    assign osc_target = s_r.from_reset
        ? CNT_W'(cssq_osc_of(s_r.clock_source_select_fuses, s_r.startup_time_fuses) + OSC_RST_EXTRA)
        : cssq_osc_of(s_r.clock_source_select_fuses, s_r.startup_time_fuses);

    cssq_tick_counter u_tout_cnt (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_clear(s_r.tout_clr),
        .i_tick(i_wdt_osc_tick),
        .i_target(tout_target),
        .o_done(tout_done)
    );

    cssq_tick_counter u_osc_cnt (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_clear(s_r.osc_clr),
        .i_tick(i_osc_tick),
        .i_target(osc_target),
        .o_done(osc_done)
    );

    always_comb begin
        logic presc_tick;
        logic running;
        logic idle_sleep;
        logic wake;
        logic [DATA_W-1:0] rd;
        presc_tick = 1'b0;
        running = 1'b0;
        idle_sleep = 1'b0;
        wake = 1'b0;
        rd = '0;
        s_nxt = s_r;
        s_nxt.tout_clr = 1'b0;
        s_nxt.osc_clr = 1'b0;
        s_nxt.rd_data = '0;
        // Async interrupt inputs wake even with the peripheral clock stopped
        wake = i_wake || i_async_irq;

        case (s_r.state)
            ST_RESET: begin
                // Fuses are caught while held here, never by the async reset
                s_nxt.clock_source_select_fuses = i_clock_source_select_fuses;
                s_nxt.startup_time_fuses = i_startup_time_fuses;
                s_nxt.div8 = i_divide_by_eight_fuse;
                s_nxt.src = cssq_src_of(i_clock_source_select_fuses);
                s_nxt.ext_en = (cssq_src_of(i_clock_source_select_fuses) != SRC_RC);
                s_nxt.presc = (i_divide_by_eight_fuse == FUSE_PROGRAMMED)
                    ? PRESC_DIV8 : PRESC_DIV1;
                s_nxt.from_reset = 1'b1;
                if (!i_reset_source && !i_brownout_detector) begin
                    s_nxt.state = ST_TOUT;
                    s_nxt.tout_clr = 1'b1;
                end
            end
            ST_TOUT: begin
                if (!s_r.tout_clr && tout_done) begin
                    s_nxt.state = ST_OSC;
                    s_nxt.osc_clr = 1'b1;
                end
            end
            ST_OSC: begin
                if (!s_r.osc_clr && osc_done) begin
                    s_nxt.state = ST_RUN;
                    s_nxt.from_reset = 1'b0;
                end
            end
            ST_RUN: begin
                if (i_wr_en && i_addr == REG_SLEEP && i_wr_data[SLEEP_GO_BIT]) begin
                    s_nxt.state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake) begin
                    if (s_r.slp_mode == SLP_IDLE) begin
                        s_nxt.state = ST_RUN;
                    end else begin
                        // Oscillator was stopped: only the start-up count applies
                        s_nxt.state = ST_OSC;
                        s_nxt.osc_clr = 1'b1;
                    end
                end
            end
            default: begin
                s_nxt.state = ST_RESET;
            end
        endcase

        // Reset sources pull the sequence back to the start from any state
        if (i_reset_source || i_brownout_detector) begin
            s_nxt.state = ST_RESET;
        end

        // Register writes
        if (i_wr_en) begin
            if (i_addr == REG_CLK_SEL) begin
                s_nxt.src = cssq_src_t'(i_wr_data[CLK_SRC_LSB +: 2]);
                s_nxt.ext_en = i_wr_data[CLK_EXT_EN_BIT];
            end else if (i_addr == REG_PRESCALE) begin
                // Out-of-range settings are ignored rather than wrapped
                if (i_wr_data[3:0] <= PRESC_MAX && i_wr_data[DATA_W-1:4] == '0) begin
                    s_nxt.presc = i_wr_data[3:0];
                    s_nxt.presc_cnt = '0;
                end
            end else if (i_addr == REG_PLL) begin
                s_nxt.pll_en = i_wr_data[PLL_EN_BIT];
            end else if (i_addr == REG_SLEEP) begin
                if (i_wr_data[1:0] <= 2'(SLP_PDOWN)) begin
                    s_nxt.slp_mode = cssq_slp_t'(i_wr_data[1:0]);
                end
            end else if (i_addr == REG_STATUS) begin
                if (i_wr_data[STAT_RESUME_BIT]) begin
                    s_nxt.resume_flag = 1'b0;
                end
            end
        end
        // Set beats the clear in the same cycle
        if (i_usb_non_idle) begin
            s_nxt.resume_flag = 1'b1;
        end

        // Register reads, answered in the next cycle only
        if (i_rd_en) begin
            if (i_addr == REG_CLK_SEL) begin
                rd[CLK_SRC_LSB +: 2] = s_r.src;
                rd[CLK_EXT_EN_BIT] = s_r.ext_en;
            end else if (i_addr == REG_PRESCALE) begin
                rd[3:0] = s_r.presc;
            end else if (i_addr == REG_PLL) begin
                rd[PLL_EN_BIT] = s_r.pll_en;
                rd[PLL_LOCK_BIT] = i_pll_locked;
            end else if (i_addr == REG_SLEEP) begin
                rd[1:0] = s_r.slp_mode;
            end else if (i_addr == REG_STATUS) begin
                rd[2:0] = s_r.state;
                rd[STAT_RESUME_BIT] = s_r.resume_flag;
                rd[STAT_RST_BIT] = s_r.int_rst;
            end else if (i_addr == REG_FUSES) begin
                rd[3:0] = s_r.clock_source_select_fuses;
                rd[FUSE_SUT_LSB +: 2] = s_r.startup_time_fuses;
                rd[FUSE_DIV8_BIT] = s_r.div8;
            end
        end
        s_nxt.rd_data = rd;

        // Prescaler keeps counting so a divided edge is never stretched by sleep
        if (!(i_wr_en && i_addr == REG_PRESCALE)) begin
            if (s_r.presc_cnt >= cssq_presc_mask(s_r.presc)) begin
                s_nxt.presc_cnt = '0;
            end else begin
                s_nxt.presc_cnt = s_r.presc_cnt + 1'b1;
            end
        end
        presc_tick = (s_r.presc_cnt >= cssq_presc_mask(s_r.presc));

        running = (s_nxt.state == ST_RUN);
        idle_sleep = (s_nxt.state == ST_SLEEP) && (s_nxt.slp_mode == SLP_IDLE);
        s_nxt.int_rst = (s_nxt.state == ST_RESET) || (s_nxt.state == ST_TOUT)
            || (s_nxt.state == ST_OSC && s_nxt.from_reset);
        s_nxt.core_en = running && presc_tick;
        s_nxt.flash_en = running && presc_tick;
        s_nxt.per_en = (running || idle_sleep) && presc_tick;
        // Oscillators stop in power-save, power-down and the reset state
        s_nxt.osc_run = !(s_nxt.state == ST_SLEEP && s_nxt.slp_mode != SLP_IDLE)
            && (s_nxt.state != ST_RESET);
        s_nxt.rc_en = s_nxt.osc_run && (s_nxt.src == SRC_RC);
        s_nxt.ext_osc = s_nxt.osc_run && s_nxt.ext_en;
        // USB domain needs a locked PLL fed at PLL_IN_MHZ by software
        s_nxt.usb_en = s_nxt.pll_en && i_pll_locked && s_nxt.osc_run;
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_r <= '0;
            s_r.state <= ST_RESET;
            s_r.clock_source_select_fuses <= CLOCK_SOURCE_SELECT_FUSES_RC;
            s_r.startup_time_fuses <= SUT_LONG;
            s_r.div8 <= FUSE_PROGRAMMED;
            s_r.src <= SRC_RC;
            s_r.presc <= PRESC_DIV8;
            s_r.from_reset <= 1'b1;
            s_r.int_rst <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rd_data = s_r.rd_data;
    assign o_int_rst = s_r.int_rst;
    assign o_core_clock_en = s_r.core_en;
    assign o_peripheral_clock_en = s_r.per_en;
    assign o_flash_interface_clock_en = s_r.flash_en;
    assign o_usb_domain_clock_en = s_r.usb_en;
    assign o_pll_en = s_r.pll_en;
    assign o_clk_src = s_r.src;
    assign o_rc_osc_en = s_r.rc_en;
    assign o_ext_osc_en = s_r.ext_osc;
    assign o_osc_run = s_r.osc_run;
endmodule : cssq_clock_sequencer

// >>> tb/cssq_osc_model.sv
`timescale 1ns/1ps
module cssq_osc_model (
    input wire logic i_core_clk,
    input wire logic i_osc_run,
    input wire logic i_pll_en,
    input wire logic i_slow,
    output logic o_osc_tick,
    output logic o_wdt_tick,
    output logic o_pll_locked
);
    logic [2:0] lock_cnt = 3'h0;
    logic phase = 1'b0;
    initial o_osc_tick = 1'b0;
    initial o_wdt_tick = 1'b0;
    initial o_pll_locked = 1'b0;
    // Stopped oscillator gives no edges; a slow part ticks every other cycle
    always @(posedge i_core_clk) begin
        phase <= ~phase;
        o_osc_tick <= i_osc_run && (!i_slow || phase);
        o_wdt_tick <= 1'b1;
        if (!(i_pll_en && i_osc_run))
            lock_cnt <= 3'h0;
        else if (lock_cnt != 3'h4)
            lock_cnt <= lock_cnt + 3'h1;
        o_pll_locked <= (lock_cnt == 3'h4);
    end
endmodule : cssq_osc_model

// >>> tb/cssq_clock_sequencer_assertions.sv
`timescale 1ns/1ps
module cssq_clock_sequencer_checker
    import cssq_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_reset_source,
    input wire logic i_brownout_detector,
    input wire logic i_pll_locked,
    input wire logic i_rd_en,
    input wire logic [DATA_W-1:0] o_rd_data,
    input wire logic o_int_rst,
    input wire logic o_core_clock_en,
    input wire logic o_peripheral_clock_en,
    input wire logic o_flash_interface_clock_en,
    input wire logic o_usb_domain_clock_en,
    input wire logic o_pll_en,
    input wire logic o_osc_run
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    sequence src_release_s;
        (i_reset_source || i_brownout_detector) ##1 !(i_reset_source || i_brownout_detector);
    endsequence
    sequence rst_hold_s;
        o_int_rst [*3];
    endsequence
    rst_follow_a: assert property ((i_reset_source || i_brownout_detector) |-> ##[1:2] o_int_rst)
        else $error("internal reset missed a reset source");
    rst_hold_a: assert property (src_release_s |-> rst_hold_s)
        else $error("internal reset released too early");
    rst_cause_a: assert property ($rose(o_int_rst) |->
        $past(i_reset_source || i_brownout_detector) || $past(i_reset_source || i_brownout_detector, 2))
        else $error("internal reset without a reset source");
    core_gate_a: assert property (o_int_rst |-> !o_core_clock_en)
        else $error("core clock during internal reset");
    flash_core_a: assert property (o_flash_interface_clock_en == o_core_clock_en)
        else $error("flash clock apart from core clock");
    periph_core_a: assert property (o_core_clock_en |-> o_peripheral_clock_en)
        else $error("core clock without peripheral clock");
    usb_lock_a: assert property (!$past(i_pll_locked) |-> !o_usb_domain_clock_en)
        else $error("usb clock without lock");
    usb_pll_a: assert property (o_usb_domain_clock_en |-> o_pll_en || $past(o_pll_en))
        else $error("usb clock with pll off");
    rd_idle_a: assert property (!$past(i_rd_en) |-> o_rd_data == '0)
        else $error("read data outside read slot");
    osc_release_a: assert property ($fell(o_int_rst) |-> $past(o_osc_run))
        else $error("reset released with oscillator off");
endmodule : cssq_clock_sequencer_checker

bind cssq_clock_sequencer cssq_clock_sequencer_checker cssq_clock_sequencer_checker_i (
    .i_core_clk, .i_sys_rst, .i_reset_source, .i_brownout_detector, .i_pll_locked, .i_rd_en,
    .o_rd_data, .o_int_rst, .o_core_clock_en, .o_peripheral_clock_en,
    .o_flash_interface_clock_en, .o_usb_domain_clock_en, .o_pll_en, .o_osc_run);

// >>> tb/clock_source_startup_sequencer_bench.sv
`timescale 1ns/1ps
module clock_source_startup_sequencer_bench;
    import cssq_pkg::*;
    logic i_core_clk, i_wdt_osc_tick, i_osc_tick, i_pll_locked, o_int_rst, o_core_clock_en;
    logic o_peripheral_clock_en, o_flash_interface_clock_en, o_usb_domain_clock_en, o_pll_en;
    logic o_rc_osc_en, o_ext_osc_en, o_osc_run;
    logic i_sys_rst = 1'b1, i_divide_by_eight_fuse = 1'b0, i_reset_source = 1'b0, slow = 1'b0;
    logic i_brownout_detector = 1'b0, i_wake = 1'b0, i_async_irq = 1'b0, i_usb_non_idle = 1'b0;
    logic i_wr_en = 1'b0, i_rd_en = 1'b0;
    logic [3:0] i_clock_source_select_fuses = 4'h2, i_addr = 4'h0, p;
    logic [1:0] i_startup_time_fuses = 2'h2, o_clk_src;
    logic [DATA_W-1:0] i_wr_data = 8'h00, o_rd_data, d;
    logic [3:0] cs [5] = '{4'h3, 4'h2, 4'h0, 4'h8, 4'h7};
    logic [1:0] ss [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h1};
    int bad_count = 0, n_checks = 0, n, g;
    cssq_clock_sequencer cssq_clock_sequencer_i (.i_core_clk, .i_sys_rst,
        .i_clock_source_select_fuses, .i_startup_time_fuses, .i_divide_by_eight_fuse,
        .i_reset_source, .i_brownout_detector, .i_wdt_osc_tick, .i_osc_tick, .i_wake,
        .i_async_irq, .i_usb_non_idle, .i_pll_locked, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en,
        .o_rd_data, .o_int_rst, .o_core_clock_en, .o_peripheral_clock_en,
        .o_flash_interface_clock_en, .o_usb_domain_clock_en, .o_pll_en, .o_clk_src,
        .o_rc_osc_en, .o_ext_osc_en, .o_osc_run);
    cssq_osc_model cssq_osc_model_i (.i_core_clk, .i_osc_run(o_osc_run), .i_pll_en(o_pll_en),
        .i_slow(slow), .o_osc_tick(i_osc_tick), .o_wdt_tick(i_wdt_osc_tick),
        .o_pll_locked(i_pll_locked));
    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end
    function automatic int tout_of(input logic [3:0] c, input logic [1:0] s);
        int i = {c[0], s};
        if (c < 4'h6) return (s == 2'h0) ? 0 : (s == 2'h1) ? 512 : 8192;
        return (i == 0 || i == 3 || i == 6) ? 512 : (i == 2 || i == 5) ? 0 : 8192;
    endfunction : tout_of
    function automatic int osc_of(input logic [3:0] c, input logic [1:0] s);
        int i = {c[0], s};
        if (c < 4'h6) return 6;
        return (i < 2) ? 258 : (i < 5) ? 1024 : 16384;
    endfunction : osc_of
    task automatic complete_run();
        if (bad_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    task automatic chk(input bit ok, input string m);
        n_checks++;
        if (!ok) begin
            bad_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_core_clk);
        i_wr_en <= 1'b1;
        i_addr <= a;
        i_wr_data <= v;
        @(posedge i_core_clk);
        i_wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge i_core_clk);
        i_rd_en <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd_en <= 1'b0;
        #1 d = o_rd_data;
    endtask : rd
    // Cycles up to the next core enable, bounded so a dead clock cannot hang
    task automatic till_core(output int c);
        c = 0;
        do begin
            @(posedge i_core_clk);
            #1 c++;
        end while (o_core_clock_en !== 1'b1 && c < 1000);
    endtask : till_core
    task automatic boot(input logic [3:0] c, input logic [1:0] s, input logic dv, input bit b);
        int e = tout_of(c, s) + osc_of(c, s) + 14;
        logic [3:0] es;
        @(posedge i_core_clk);
        i_clock_source_select_fuses <= c;
        i_startup_time_fuses <= s;
        i_divide_by_eight_fuse <= dv;
        if (b) i_brownout_detector <= 1'b1;
        else i_reset_source <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        i_reset_source <= 1'b0;
        i_brownout_detector <= 1'b0;
        n = 0;
        do begin
            @(posedge i_core_clk);
            #1 n++;
        end while (o_int_rst !== 1'b0 && n < 40000);
        chk(n >= e && n <= e + 12, "start-up length");
        rd(REG_FUSES);
        chk(d === {1'b0, dv, s, c}, "fuse readback");
        // Expected {source, RC enable, external enable}; reserved codes run on RC
        es = (c >= 4'h8) ? 4'h9 : (c >= 4'h6) ? 4'hD : (c == 4'h0) ? 4'h1 : 4'h6;
        chk({o_clk_src, o_rc_osc_en, o_ext_osc_en} === es, "source decode");
        till_core(n);
        till_core(g);
        chk(g == (dv ? 1 : 8), "boot divider");
    endtask : boot
    task automatic nap(input logic [7:0] cmd, input int pexp, input int lo, input int hi,
            input bit irq);
        wr(REG_SLEEP, cmd);
        repeat (3) @(posedge i_core_clk);
        n = 0;
        g = 0;
        repeat (16) begin
            @(posedge i_core_clk);
            #1 n += o_core_clock_en;
            g += o_peripheral_clock_en;
        end
        chk(n == 0 && g == pexp, "sleep gating");
        chk(o_osc_run === (pexp != 0), "oscillator in sleep");
        if (irq) i_async_irq <= 1'b1;
        else i_wake <= 1'b1;
        @(posedge i_core_clk);
        i_async_irq <= 1'b0;
        i_wake <= 1'b0;
        till_core(n);
        chk(n >= lo && n <= hi && o_int_rst === 1'b0, "wake length");
    endtask : nap
    initial begin
        repeat (90000) @(posedge i_core_clk);
        bad_count++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h816A6D3A));
        repeat (8) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        boot(4'h2, 2'h2, 1'b0, 1'b0);
        for (int k = 0; k < 5; k++) begin
            p = (k == 0) ? 4'h0 : (k == 1) ? 4'h8 : 4'($urandom_range(7, 1));
            wr(REG_PRESCALE, {4'h0, p});
            till_core(n);
            till_core(g);
            chk(g == (1 << p), "prescaler gap");
        end
        wr(REG_PRESCALE, 8'h09);
        till_core(n);
        till_core(g);
        chk(g == (1 << p), "bad prescaler accepted");
        wr(REG_PRESCALE, 8'h00);
        wr(REG_CLK_SEL, 8'h01);
        @(posedge i_core_clk);
        #1 chk(o_clk_src === 2'h1 && o_ext_osc_en === 1'b0, "suspend switch");
        @(posedge i_core_clk);
        i_usb_non_idle <= 1'b1;
        @(posedge i_core_clk);
        i_usb_non_idle <= 1'b0;
        rd(REG_STATUS);
        chk(d[4:0] === 5'h0B, "resume flag");
        wr(REG_STATUS, 8'h08);
        rd(REG_STATUS);
        chk(d[3] === 1'b0, "resume clear");
        wr(REG_CLK_SEL, 8'h04);
        @(posedge i_core_clk);
        #1 chk(o_clk_src === 2'h0 && o_ext_osc_en === 1'b1, "resume switch");
        wr(REG_PLL, 8'h01);
        repeat (10) @(posedge i_core_clk);
        rd(REG_PLL);
        chk(d === 8'h03 && o_usb_domain_clock_en === 1'b1, "usb clock on");
        wr(REG_PLL, 8'h00);
        repeat (3) @(posedge i_core_clk);
        #1 chk(o_usb_domain_clock_en === 1'b0 && o_pll_en === 1'b0, "usb clock off");
        wr(4'hF, 8'hFF);
        rd(4'hF);
        chk(d === 8'h00, "unmapped read");
        wr(REG_CLK_SEL, 8'h01);
        nap(8'h80, 16, 0, 3, 1'b0);
        nap(8'h82, 0, 6, 16, 1'b1);
        nap(8'h81, 0, 6, 16, 1'b0);
        slow <= 1'b1;
        nap(8'h82, 0, 12, 30, 1'b0);
        slow <= 1'b0;
        ss[1] = 2'($urandom_range(1, 0));
        for (int k = 0; k < 5; k++)
            boot(cs[k], ss[k], k != 1, tout_of(cs[k], ss[k]) == 0);
        complete_run();
    end
endmodule : clock_source_startup_sequencer_bench
